// [ircv_pkg.sv]
// Purpose: Constants and types for the two-wire receive status controller
// Assumes: 32-bit APB, 50 MHz pclk
// Notes: Register offsets are byte addresses
package ircv_pkg;
    // Register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_DATA = 8'h08;
    localparam logic [7:0] ADR_OWN = 8'h0C;
    localparam logic [7:0] ADR_EVT = 8'h10;
    localparam logic [7:0] ADR_MASK = 8'h14;
    // Control bit positions: flag inside the packed control fields, master reset beyond them
    localparam int CB_SI = 1;
    localparam int CB_SMBR = 5;
    // Status codes
    localparam logic [7:0] SC_START = 8'h08;
    localparam logic [7:0] SC_RSTART = 8'h10;
    localparam logic [7:0] SC_AW_ACK = 8'h18;
    localparam logic [7:0] SC_AW_NACK = 8'h20;
    localparam logic [7:0] SC_ARB = 8'h38;
    localparam logic [7:0] SC_AR_ACK = 8'h40;
    localparam logic [7:0] SC_AR_NACK = 8'h48;
    localparam logic [7:0] SC_MD_ACK = 8'h50;
    localparam logic [7:0] SC_MD_NACK = 8'h58;
    localparam logic [7:0] SC_OWN_W = 8'h60;
    localparam logic [7:0] SC_ARB_OWN = 8'h68;
    localparam logic [7:0] SC_GC = 8'h70;
    localparam logic [7:0] SC_ARB_GC = 8'h78;
    localparam logic [7:0] SC_SD_ACK = 8'h80;
    localparam logic [7:0] SC_SD_NACK = 8'h88;
    localparam logic [7:0] SC_GD_ACK = 8'h90;
    localparam logic [7:0] SC_GD_NACK = 8'h98;
    localparam logic [7:0] SC_SSTOP = 8'hA0;
    localparam logic [7:0] SC_SMBRST = 8'hD0;
    localparam logic [7:0] SC_IDLE = 8'hF8;
    localparam logic [7:0] GC_ADDR = 8'h00;
    // Reset values
    localparam logic [7:0] OWN_RST = 8'h00;
    localparam logic [2:0] MASK_RST = 3'h0;
    // Timing
    localparam int CLK_NS = 20;
    localparam int QTR_NS = 2500;
    localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int SMB_RST_MS = 35;
    localparam int SMB_RST_CYC = SMB_RST_MS * (1000000 / CLK_NS);
    // Control register fields, bits 4..0
    typedef struct packed {
        logic en;
        logic start_request_bit;
        logic stop_request_bit;
        logic si;
        logic aa;
    } ircv_ctrl_s;
    // One-hot controller states
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_MSTART = 8'h02,
        ST_MBIT = 8'h04,
        ST_MHOLD = 8'h08,
        ST_MSTOP = 8'h10,
        ST_SBIT = 8'h20,
        ST_SHOLD = 8'h40,
        ST_SMBRST = 8'h80
    } ircv_state_e;
endpackage

// [ircv_ctrl.sv]
// Purpose: Two-wire bus controller, master receive and slave receive status machine
// Assumes: Open-drain pins, oe_n low pulls the line low; APB zero wait state
// Notes: Function
// Function
// - After start sent post 08, then send loaded read address and sample ack
// - After repeated start post 10; read address sent, write address posts 18 or 20 and waits for stop or restart
// - Arbitration lost in not-ack bit posts 38; release, or restart when bus free
// - Codes 40 and 50 receive next byte, acking only when ack enable is set
// - Read address not acked posts 48; restart, stop, or stop then start
// - Byte nacked posts 58; software picks restart, stop, or both; stop self-clears
// - Master reset posts D0, flag rises after 35 ms, clearing returns to F8
// - Own write address acked posts 60, next byte acked per ack enable
// - Addressed after lost arbitration posts 68 own or 78 general call
// - General call address acked while idle posts 70, data acked per ack enable
// - Own-addressed data byte acked posts 80, then receive next byte
// - Status resets to F8 and every posted code raises the interrupt flag
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ircv_ctrl #(
    parameter int QTR_CYC = ircv_pkg::QTR_CYC,
    parameter int SMB_CYC = ircv_pkg::SMB_RST_CYC
)(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Two-wire link pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // Interrupt
    output logic irq
);
    localparam int CW = $clog2(SMB_CYC + 2);
    localparam logic [CW-1:0] QEND = CW'(QTR_CYC - 1);
    localparam logic [CW-1:0] SEND = CW'(SMB_CYC - 1);
    localparam logic [CW-1:0] SDONE = CW'(SMB_CYC);

    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [1:0] scl_sy_q, sda_sy_q;
    logic scl_p_q, sda_p_q;
    ircv_pkg::ircv_state_e st_q, st_d;
    ircv_pkg::ircv_ctrl_s ctl_q, ctl_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [1:0] ph_q, ph_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, stat_q, stat_d, data_q, data_d, own_q, own_d, pcode;
    logic [2:0] ev_q, ev_d, mask_q, mask_d;
    logic scl_oe_n_q, scl_oe_n_d, sda_oe_n_q, sda_oe_n_d, irq_q, irq_d;
    logic busy_q, busy_d, mrx_q, mrx_d, adp_q, adp_d, gc_q, gc_d, al_q, al_d;
    logic ack_q, ack_d, adr_q, adr_d, rep_q, rep_d;
    logic post, al_ev, s, tick, scl_rise, scl_fall, start_det, stop_det;
    logic wr, wr_ctrl, own_m, gc_m;

    // Synchronised line levels and bus conditions
    assign s = sda_sy_q[1];
    assign scl_rise = scl_sy_q[1] & ~scl_p_q;
    assign scl_fall = ~scl_sy_q[1] & scl_p_q;
    assign start_det = scl_sy_q[1] & scl_p_q & sda_p_q & ~s;
    assign stop_det = scl_sy_q[1] & scl_p_q & ~sda_p_q & s;
    assign tick = (cnt_q == QEND);
    assign wr = psel & penable & pready_q & pwrite;
    assign wr_ctrl = wr && (paddr == ircv_pkg::ADR_CTRL);
    assign own_m = (sh_q[7:1] == own_q[7:1]) && !sh_q[0];
    assign gc_m = (sh_q == ircv_pkg::GC_ADDR) && own_q[0];

    // APB answer, registered in the setup cycle so access has no wait state
    always_comb
    begin
        pready_d = psel & ~penable;
        pslverr_d = 1'b0;
        prdata_d = 32'h0000_0000;
        if (psel && !penable)
        begin
            if (paddr == ircv_pkg::ADR_CTRL)
                prdata_d = {27'h0, ctl_q};
            else if (paddr == ircv_pkg::ADR_STAT)
                prdata_d = {24'h0, stat_q};
            else if (paddr == ircv_pkg::ADR_DATA)
                prdata_d = {24'h0, data_q};
            else if (paddr == ircv_pkg::ADR_OWN)
                prdata_d = {24'h0, own_q};
            else if (paddr == ircv_pkg::ADR_EVT)
                prdata_d = {29'h0, ev_q};
            else if (paddr == ircv_pkg::ADR_MASK)
                prdata_d = {29'h0, mask_q};
            else
                pslverr_d = 1'b1; // Unmapped offset
        end
    end

    // Status machine, control and event registers
    always_comb
    begin
        st_d = st_q;
        ctl_d = ctl_q;
        cnt_d = tick ? '0 : cnt_q + CW'(1);
        ph_d = ph_q;
        bit_d = bit_q;
        sh_d = sh_q;
        stat_d = stat_q;
        data_d = data_q;
        own_d = own_q;
        ev_d = ev_q;
        mask_d = mask_q;
        scl_oe_n_d = scl_oe_n_q;
        sda_oe_n_d = sda_oe_n_q;
        busy_d = busy_q;
        mrx_d = mrx_q;
        adp_d = adp_q;
        gc_d = gc_q;
        al_d = al_q;
        ack_d = ack_q;
        adr_d = adr_q;
        rep_d = rep_q;
        post = 1'b0;
        al_ev = 1'b0;
        pcode = stat_q;
        // Software writes; a zero written to the flag clears it
        if (wr_ctrl)
        begin
            ctl_d = ircv_pkg::ircv_ctrl_s'(pwdata[4:0]);
            ctl_d.si = ctl_q.si & pwdata[ircv_pkg::CB_SI];
        end
        if (wr && paddr == ircv_pkg::ADR_DATA)
            data_d = pwdata[7:0];
        if (wr && paddr == ircv_pkg::ADR_OWN)
            own_d = pwdata[7:0];
        if (wr && paddr == ircv_pkg::ADR_MASK)
            mask_d = pwdata[2:0];
        if (wr && paddr == ircv_pkg::ADR_EVT)
            ev_d = ev_q & ~pwdata[2:0];
        case (st_q)
            ircv_pkg::ST_IDLE:
            begin
                scl_oe_n_d = 1'b1;
                sda_oe_n_d = 1'b1;
                if (start_det)
                begin
                    st_d = ircv_pkg::ST_SBIT;
                    bit_d = 4'hF; // Start's own falling edge brings it to 0
                    adp_d = 1'b1;
                    adr_d = 1'b0;
                    al_d = 1'b0;
                end
                else if (ctl_q.start_request_bit && !ctl_q.si && !busy_q)
                begin
                    st_d = ircv_pkg::ST_MSTART;
                    rep_d = 1'b0;
                    ph_d = 2'h0;
                    cnt_d = '0;
                end
            end
            ircv_pkg::ST_MSTART:
            begin
                if (tick && ph_q == 2'h0)
                begin
                    scl_oe_n_d = 1'b1;
                    ph_d = 2'h1;
                end
                else if (tick && ph_q == 2'h1 && scl_sy_q[1])
                begin
                    sda_oe_n_d = 1'b0;
                    ph_d = 2'h2;
                end
                else if (tick && ph_q == 2'h2)
                begin
                    scl_oe_n_d = 1'b0;
                    post = 1'b1;
                    pcode = rep_q ? ircv_pkg::SC_RSTART : ircv_pkg::SC_START;
                    st_d = ircv_pkg::ST_MHOLD;
                end
            end
            ircv_pkg::ST_MHOLD:
            begin
                // Clock held low until software clears the flag
                if (!ctl_q.si)
                begin
                    ph_d = 2'h0;
                    bit_d = 4'h0;
                    cnt_d = '0;
                    if (stat_q == ircv_pkg::SC_START || stat_q == ircv_pkg::SC_RSTART)
                    begin
                        sh_d = data_q;
                        mrx_d = data_q[0];
                        adp_d = 1'b1;
                        sda_oe_n_d = data_q[7];
                        st_d = ircv_pkg::ST_MBIT;
                    end
                    else if (stat_q == ircv_pkg::SC_AR_ACK || stat_q == ircv_pkg::SC_MD_ACK)
                    begin
                        sh_d = 8'hFF;
                        adp_d = 1'b0;
                        sda_oe_n_d = 1'b1;
                        st_d = ircv_pkg::ST_MBIT;
                    end
                    else if (stat_q == ircv_pkg::SC_AR_NACK || stat_q == ircv_pkg::SC_MD_NACK
                        || stat_q == ircv_pkg::SC_AW_ACK || stat_q == ircv_pkg::SC_AW_NACK)
                    begin
                        if (ctl_q.stop_request_bit)
                        begin
                            sda_oe_n_d = 1'b0;
                            st_d = ircv_pkg::ST_MSTOP;
                        end
                        else if (ctl_q.start_request_bit)
                        begin
                            sda_oe_n_d = 1'b1;
                            rep_d = 1'b1;
                            st_d = ircv_pkg::ST_MSTART;
                        end
                    end
                end
            end
            ircv_pkg::ST_MBIT:
            begin
                if (tick && ph_q == 2'h0)
                begin
                    scl_oe_n_d = 1'b1;
                    ph_d = 2'h1;
                end
                else if (tick && ph_q == 2'h1 && scl_sy_q[1])
                begin
                    ph_d = 2'h2;
                    if (bit_q < 4'h8)
                        sh_d = {sh_q[6:0], s};
                    else
                        ack_d = !s;
                    if (bit_q < 4'h8 && adp_q && sh_q[7] && !s)
                    begin
                        // Lost in the address: keep listening as a responder
                        sda_oe_n_d = 1'b1;
                        al_d = 1'b1;
                        al_ev = 1'b1;
                        st_d = ircv_pkg::ST_SBIT;
                    end
                    else if (bit_q == 4'h8 && !adp_q && !ctl_q.aa && !s)
                    begin
                        sda_oe_n_d = 1'b1;
                        al_ev = 1'b1;
                        post = 1'b1;
                        pcode = ircv_pkg::SC_ARB;
                        st_d = ircv_pkg::ST_IDLE;
                    end
                end
                else if (tick && ph_q == 2'h2)
                begin
                    scl_oe_n_d = 1'b0;
                    ph_d = 2'h3;
                end
                else if (tick && ph_q == 2'h3)
                begin
                    ph_d = 2'h0;
                    if (bit_q == 4'h8)
                    begin
                        sda_oe_n_d = 1'b1;
                        post = 1'b1;
                        st_d = ircv_pkg::ST_MHOLD;
                        if (!adp_q)
                        begin
                            data_d = sh_q;
                            pcode = ack_q ? ircv_pkg::SC_MD_ACK : ircv_pkg::SC_MD_NACK;
                        end
                        else if (mrx_q)
                            pcode = ack_q ? ircv_pkg::SC_AR_ACK : ircv_pkg::SC_AR_NACK;
                        else
                            pcode = ack_q ? ircv_pkg::SC_AW_ACK : ircv_pkg::SC_AW_NACK;
                    end
                    else
                    begin
                        bit_d = bit_q + 4'h1;
                        if (bit_q < 4'h7)
                            sda_oe_n_d = adp_q ? sh_q[7] : 1'b1;
                        else
                            sda_oe_n_d = adp_q ? 1'b1 : !ctl_q.aa;
                    end
                end
            end
            ircv_pkg::ST_MSTOP:
            begin
                if (tick && ph_q == 2'h0)
                begin
                    scl_oe_n_d = 1'b1;
                    ph_d = 2'h1;
                end
                else if (tick && ph_q == 2'h1 && scl_sy_q[1])
                begin
                    sda_oe_n_d = 1'b1;
                    ph_d = 2'h2;
                end
                else if (tick && ph_q == 2'h2)
                begin
                    // Start request still set gives stop then start
                    ctl_d.stop_request_bit = 1'b0;
                    stat_d = ircv_pkg::SC_IDLE;
                    st_d = ircv_pkg::ST_IDLE;
                end
            end
            ircv_pkg::ST_SBIT:
            begin
                if (stop_det || start_det)
                begin
                    sda_oe_n_d = 1'b1;
                    post = adr_q;
                    pcode = ircv_pkg::SC_SSTOP;
                    st_d = stop_det ? ircv_pkg::ST_IDLE : ircv_pkg::ST_SBIT;
                    bit_d = 4'hF;
                    adp_d = 1'b1;
                    adr_d = 1'b0;
                    al_d = 1'b0;
                end
                else if (scl_rise && bit_q < 4'h8)
                    sh_d = {sh_q[6:0], s};
                else if (scl_fall)
                begin
                    bit_d = bit_q + 4'h1;
                    if (bit_q == 4'h7)
                    begin
                        ack_d = ctl_q.aa;
                        if (adp_q && !(ctl_q.aa && (own_m || gc_m)))
                            st_d = ircv_pkg::ST_IDLE; // Not addressed
                        else
                            sda_oe_n_d = !ctl_q.aa;
                        if (adp_q)
                        begin
                            adr_d = 1'b1;
                            gc_d = gc_m;
                        end
                    end
                    else if (bit_q == 4'h8)
                    begin
                        sda_oe_n_d = 1'b1;
                        scl_oe_n_d = 1'b0; // Stretch until software answers
                        post = 1'b1;
                        adp_d = 1'b0;
                        st_d = ircv_pkg::ST_SHOLD;
                        if (adp_q && gc_q)
                            pcode = al_q ? ircv_pkg::SC_ARB_GC : ircv_pkg::SC_GC;
                        else if (adp_q)
                            pcode = al_q ? ircv_pkg::SC_ARB_OWN : ircv_pkg::SC_OWN_W;
                        else if (gc_q)
                            pcode = ack_q ? ircv_pkg::SC_GD_ACK : ircv_pkg::SC_GD_NACK;
                        else
                            pcode = ack_q ? ircv_pkg::SC_SD_ACK : ircv_pkg::SC_SD_NACK;
                        if (!adp_q)
                            data_d = sh_q;
                    end
                end
            end
            ircv_pkg::ST_SHOLD:
            begin
                if (!ctl_q.si)
                begin
                    scl_oe_n_d = 1'b1;
                    bit_d = 4'h0;
                    adr_d = ack_q;
                    st_d = ack_q ? ircv_pkg::ST_SBIT : ircv_pkg::ST_IDLE;
                end
            end
            ircv_pkg::ST_SMBRST:
            begin
                scl_oe_n_d = 1'b1;
                sda_oe_n_d = 1'b1;
                if (cnt_q == SEND)
                begin
                    post = 1'b1;
                    cnt_d = SDONE;
                end
                else if (cnt_q == SDONE)
                begin
                    cnt_d = SDONE;
                    if (!ctl_q.si)
                    begin
                        stat_d = ircv_pkg::SC_IDLE;
                        st_d = ircv_pkg::ST_IDLE;
                    end
                end
                else
                    cnt_d = cnt_q + CW'(1);
            end
            default:
                st_d = ircv_pkg::ST_IDLE;
        endcase
        // Master reset request overrides, code shows at once, flag later
        if (wr_ctrl && pwdata[ircv_pkg::CB_SMBR])
        begin
            st_d = ircv_pkg::ST_SMBRST;
            stat_d = ircv_pkg::SC_SMBRST;
            cnt_d = '0;
            scl_oe_n_d = 1'b1;
            sda_oe_n_d = 1'b1;
        end
        else if (!ctl_q.en && st_q != ircv_pkg::ST_SMBRST)
        begin
            st_d = ircv_pkg::ST_IDLE;
            scl_oe_n_d = 1'b1;
            sda_oe_n_d = 1'b1;
        end
        // Posting sets the flag after any software clear: set wins
        if (post)
        begin
            stat_d = pcode;
            ctl_d.si = 1'b1;
            ev_d[0] = 1'b1;
        end
        if (al_ev)
            ev_d[1] = 1'b1;
        if (stop_det)
            ev_d[2] = 1'b1;
        if (start_det)
            busy_d = 1'b1;
        else if (stop_det)
            busy_d = 1'b0;
        irq_d = |(ev_q & mask_q);
    end

    // Registers; the first sync stage feeds only the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            scl_sy_q <= 2'h3;
            sda_sy_q <= 2'h3;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            st_q <= ircv_pkg::ST_IDLE;
            ctl_q <= '0;
            cnt_q <= '0;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            stat_q <= ircv_pkg::SC_IDLE;
            data_q <= 8'h00;
            own_q <= ircv_pkg::OWN_RST;
            ev_q <= 3'h0;
            mask_q <= ircv_pkg::MASK_RST;
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
            irq_q <= 1'b0;
            {busy_q, mrx_q, adp_q, gc_q, al_q, ack_q, adr_q, rep_q} <= 8'h00;
        end
        else
        begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            scl_sy_q <= {scl_sy_q[0], scl_i};
            sda_sy_q <= {sda_sy_q[0], sda_i};
            scl_p_q <= scl_sy_q[1];
            sda_p_q <= sda_sy_q[1];
            st_q <= st_d;
            ctl_q <= ctl_d;
            cnt_q <= cnt_d;
            ph_q <= ph_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            stat_q <= stat_d;
            data_q <= data_d;
            own_q <= own_d;
            ev_q <= ev_d;
            mask_q <= mask_d;
            scl_oe_n_q <= scl_oe_n_d;
            sda_oe_n_q <= sda_oe_n_d;
            irq_q <= irq_d;
            {busy_q, mrx_q, adp_q, gc_q, al_q, ack_q, adr_q, rep_q} <=
                {busy_d, mrx_d, adp_d, gc_d, al_d, ack_d, adr_d, rep_d};
        end
    end

    // Open-drain: data level always low, enables decide the wire
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign scl_oe_n = scl_oe_n_q;
    assign sda_oe_n = sda_oe_n_q;
    assign irq = irq_q;
endmodule

// [ircv_props.sv]
// Purpose: Port assertions for the receive status controller
// Assumes: Zero wait APB, quarter bit of QTR_CYC clocks
// Notes: Sees only ports; bound to every controller below
`timescale 1ns/1ps
module ircv_props #(parameter int QTR_CYC = 2, parameter int SMB_CYC = 200)(
    // Clock, reset and APB
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    // Link pins and interrupt
    input wire logic scl_i, scl_o, scl_oe_n, sda_i, sda_o, sda_oe_n, irq
);
    logic [15:0] run_q, run_d;
    logic last_q, acc;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Clocks since scl last changed; saturates so long idle never wraps
    always_comb run_d = (scl_oe_n != last_q) ? 16'h0000 : run_q + {15'h0000, ~&run_q};
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) {run_q, last_q} <= {16'h0000, 1'b1};
        else {run_q, last_q} <= {run_d, scl_oe_n};
    assign acc = psel && penable && pready;
    ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
    unmap_a: assert property (psel && !penable && paddr > ircv_pkg::ADR_MASK
        |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    mapped_a: assert property (psel && !penable && paddr <= ircv_pkg::ADR_MASK
        && paddr[1:0] == 2'h0 |=> !pslverr) else $error("mapped refused");
    idle_a: assert property (!(psel && penable) |-> !pready && !pslverr) else $error("stray ready");
    rst_a: assert property ($rose(presetn) |-> scl_oe_n && sda_oe_n && !irq)
        else $error("pins busy after reset");
    phase_a: assert property (scl_oe_n != last_q |-> run_q >= QTR_CYC - 1)
        else $error("scl phase too short");
    mask_a: assert property (acc && pwrite && paddr == ircv_pkg::ADR_MASK && pwdata[2:0] == 3'h0
        |=> ##1 !irq) else $error("masked irq high");
    smb_a: assert property (acc && pwrite && paddr == ircv_pkg::ADR_CTRL && pwdata[5] ##3
        acc && !pwrite && paddr == ircv_pkg::ADR_STAT |-> prdata[7:0] == ircv_pkg::SC_SMBRST)
        else $error("no reset code");
    cover property (acc && pwrite && paddr == ircv_pkg::ADR_CTRL && pwdata[5]);
    cover property (acc && !pwrite && paddr == ircv_pkg::ADR_STAT && prdata[7:0] == 8'h50);
    cover property ($rose(irq));
endmodule
bind ircv_ctrl ircv_props #(.QTR_CYC(QTR_CYC), .SMB_CYC(SMB_CYC)) props_u (.pclk, .presetn,
    .psel, .penable, .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .scl_i, .scl_o,
    .scl_oe_n, .sda_i, .sda_o, .sda_oe_n, .irq);

// [ircv_peer.sv]
// Purpose: Far-side responder that answers one address with one byte
// Assumes: scl and sda are pulled-up wire levels
// Notes: Only ever pulls sda; released slots float high
`timescale 1ns/1ps
module ircv_peer #(parameter logic [6:0] ADDR = 7'h2A, parameter logic [7:0] BYTE = 8'h5A)(
    // Clock and wire levels
    input wire logic pclk, scl, sda,
    // Data line pull, low pulls down
    output logic pull_n = 1'b1
);
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    logic rd = 1'b0;
    logic [7:0] sh = 8'h00;
    int n = 100;
    // Frame tracking; data moves only after scl falls
    always @(posedge pclk)
    begin
        {scl_q, sda_q} <= {scl, sda};
        if (scl && scl_q && sda_q != sda)
        begin
            n <= sda ? 100 : -1; // Stop parks, start restarts the frame
            pull_n <= 1'b1;
        end
        else if (scl && !scl_q)
            sh <= {sh[6:0], sda};
        else if (!scl && scl_q)
        begin
            n <= n + 1;
            if (n == 7)
            begin
                rd <= sh == {ADDR, 1'b1};
                pull_n <= sh[7:1] != ADDR; // Ack own address only
            end
            else
                pull_n <= !(rd && n >= 8 && n <= 15) || BYTE[15 - n]; // MSB first
        end
    end
endmodule

// [testbench.sv]
// Purpose: Self-checking bench for the receive status controller
// Assumes: Peer answers address 2A with byte 5A
// Notes: Short quarter and master-reset counts keep the run brief
`timescale 1ns/1ps
module testbench;
    localparam int SMB = 200;
    localparam logic [7:0] CT = ircv_pkg::ADR_CTRL, ST = ircv_pkg::ADR_STAT;
    localparam logic [7:0] DA = ircv_pkg::ADR_DATA, EV = ircv_pkg::ADR_EVT;
    logic pclk = 1'b0, presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, scl_oe_n, sda_oe_n, pull_n, irq, err;
    wire scl = scl_oe_n;
    wire sda = sda_oe_n & pull_n;
    int n_mismatch = 0;
    int tests_run = 0;
    time t0;
    initial forever #10 pclk = ~pclk;
    // Controller with a 200 ns bit (scl sync adds a quarter to the high phase) and short master reset
    ircv_ctrl #(.QTR_CYC(2), .SMB_CYC(SMB)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_i(scl), .scl_o(), .scl_oe_n,
        .sda_i(sda), .sda_o(), .sda_oe_n, .irq);
    ircv_peer peer_u (.pclk, .scl, .sda, .pull_n);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic give_up;
        $display("mismatch at %0t: wait ran out", $time);
        n_mismatch++;
        tally_and_finish();
    endtask
    // One APB transfer, held until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (k >= 20)
            give_up();
        {rv, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    // Clear event, release the action, poll until bits m are set, check status
    task automatic go(input logic [7:0] c, pa, m, code);
        int k;
        apb(1'b1, EV, 32'h1);
        apb(1'b1, CT, {24'h0, c}); // Flag cleared only after other writes
        k = 0;
        do
        begin
            apb(1'b0, pa, 32'h0);
            k++;
        end
        while ((rv[7:0] & m) !== m && k < 400);
        if (k >= 400)
            give_up();
        apb(1'b0, ST, 32'h0);
        chk(rv, {24'h0, code});
    endtask
    // Refusals, master read paths, master reset
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ST, 32'h0);
        chk(rv, 32'hF8);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        go(8'h18, EV, 8'h01, 8'h08);
        chk({31'h0, irq}, 32'h0); // Masked event stays quiet
        apb(1'b1, ircv_pkg::ADR_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        #1;
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, DA, 32'h57);
        go(8'h10, EV, 8'h01, 8'h48);
        go(8'h1C, EV, 8'h01, 8'h08);
        apb(1'b0, CT, 32'h0);
        chk({31'h0, rv[2]}, 32'h0);
        apb(1'b1, DA, 32'h57);
        go(8'h10, EV, 8'h01, 8'h48);
        go(8'h18, EV, 8'h01, 8'h10);
        apb(1'b1, DA, 32'h55);
        go(8'h11, EV, 8'h01, 8'h40);
        go(8'h11, EV, 8'h01, 8'h50);
        apb(1'b0, DA, 32'h0);
        chk(rv, 32'h5A);
        go(8'h10, EV, 8'h01, 8'h58);
        apb(1'b0, DA, 32'h0);
        chk(rv, 32'hFF);
        go(8'h14, ST, 8'hF8, 8'hF8);
        apb(1'b0, CT, 32'h0);
        chk(rv, 32'h10);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, CT, 32'h30);
        t0 = $time;
        apb(1'b0, ST, 32'h0);
        chk(rv, 32'hD0);
        go(8'h12, CT, 8'h02, 8'hD0);
        chk({31'h0, $time - t0 >= SMB * 20}, 32'h1);
        apb(1'b1, ircv_pkg::ADR_MASK, 32'h0);
        go(8'h10, ST, 8'hF8, 8'hF8);
        tally_and_finish();
    end
endmodule
